/* File: design/port_bank_pkg.sv */
`default_nettype none
// Shared constants and carriers of the per-port tree and PTP register bank.
package port_bank_pkg;
	// Register index; the byte address on the bus is four times the index.
	localparam logic [11:0] IDX_TREE_POINTER = 12'hB01;
	localparam logic [11:0] IDX_TREE_STATE   = 12'hB04;
	localparam logic [11:0] IDX_RX_LATENCY   = 12'hC00;
	localparam logic [11:0] IDX_TX_LATENCY   = 12'hC02;
	localparam logic [11:0] IDX_ASYMMETRY    = 12'hC04;
	localparam logic [11:0] IDX_DREQ_HIGH    = 12'hC08;
	localparam logic [11:0] IDX_DREQ_LOW     = 12'hC0A;
	localparam logic [11:0] IDX_SYNC_HIGH    = 12'hC0C;
	localparam logic [11:0] IDX_SYNC_LOW     = 12'hC0E;
	localparam logic [11:0] IDX_PEER_HIGH    = 12'hC10;
	localparam logic [11:0] IDX_PEER_LOW     = 12'hC12;
	localparam logic [11:0] IDX_STAMP_FLAGS  = 12'hC14;
	// Bus geometry.
	localparam int ADDR_W = 14;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Tree state layout and reset.
	localparam int INSTANCES   = 8;
	localparam int POINTER_W   = 3;
	localparam int TX_BIT      = 2;
	localparam int RX_BIT      = 1;
	localparam int LEARN_BIT   = 0;
	localparam logic [2:0] TREE_STATE_RESET = 3'h6;
	localparam logic [POINTER_W-1:0] POINTER_RESET = 3'h0;
	// PTP register reset values and fields.
	localparam logic [15:0] RX_LATENCY_RESET = 16'h019F;
	localparam logic [15:0] TX_LATENCY_RESET = 16'h002D;
	localparam logic [15:0] ASYMMETRY_RESET  = 16'h0000;
	localparam logic [31:0] STAMP_RESET      = 32'h0000_0000;
	localparam int SIGN_BIT      = 15;
	localparam int FLAG_SYNC_BIT = 15;
	localparam int FLAG_DREQ_BIT = 14;
	localparam int FLAG_PEER_BIT = 13;
	// Egress timestamp classes.
	typedef enum logic [1:0] {STAMP_DELAY_REQ, STAMP_SYNC, STAMP_PEER_RESP} stamp_class_e;
	// PTP message kinds seen by the correction path.
	typedef enum logic [2:0] {MSG_SYNC, MSG_PEER_RESP, MSG_DELAY_REQ, MSG_PEER_REQ, MSG_OTHER} msg_e;
	// One captured egress timestamp.
	typedef struct packed {
		logic         valid;
		stamp_class_e class_id;
		logic [31:0]  value;
	} stamp_s;
	// One correction field in flight; egress is 1 for frames leaving the port.
	typedef struct packed {
		logic        valid;
		logic        egress;
		msg_e        msg;
		logic [31:0] value;
	} correction_s;
endpackage
`default_nettype wire

/* File: design/port_ptp_tree_bank.sv */
// Notes on behaviour
// R1 - Eight tree instances, selected by instance pointer.
// R2 - State bit 2 gates transmit, resets 1.
// R3 - State bit 1 gates receive, resets 1.
// R4 - State bit 0 stops learning, resets 0.
// R5 - Receive latency sixteen bits, resets 415.
// R6 - Transmit latency sixteen bits, resets 45.
// R7 - Asymmetry bit 15 is sign, resets 0.
// R8 - Add asymmetry on ingress Sync, Pdelay_Resp.
// R9 - Subtract asymmetry on egress delay requests.
// R10 - Read-only delay request stamp, two words.
// R11 - Read-only Sync stamp, two words.
// R12 - Read-only peer response stamp, two words.
// R13 - New stamp sets flag; write-one clears.
// R14 - Stamp pair held until next same class.
`timescale 1ns/1ps
`default_nettype none
module port_ptp_tree_bank (
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	input  wire logic [port_bank_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                             awvalid,
	output logic                                  awready,
	input  wire logic [31:0]                      wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output logic                                  wready,
	output logic [1:0]                            bresp,
	output logic                                  bvalid,
	input  wire logic                             bready,
	input  wire logic [port_bank_pkg::ADDR_W-1:0] araddr,
	input  wire logic                             arvalid,
	output logic                                  arready,
	output logic [31:0]                           rdata,
	output logic [1:0]                            rresp,
	output logic                                  rvalid,
	input  wire logic                             rready,
	input  wire port_bank_pkg::stamp_s            stamp_in,
	input  wire port_bank_pkg::correction_s       correction_in,
	output port_bank_pkg::correction_s            correction_out,
	output logic [7:0]                            tx_enable,
	output logic [7:0]                            rx_enable,
	output logic [7:0]                            learn_disable,
	output logic [15:0]                           receive_path_delay_ns,
	output logic [15:0]                           transmit_path_delay_ns,
	output logic                                  stamp_event
);
	// Signed asymmetry in nanoseconds, widened to the correction width.
	// The register holds sign and magnitude, not two's complement, so the
	// magnitude is zero-extended first and negated only when the sign is set.
	// A negative zero therefore behaves exactly like a positive zero.
	function automatic logic signed [31:0] asym_value(input logic [15:0] r);
		// Magnitude field, zero-extended to the full correction width.
		logic signed [31:0] mag;
		mag = signed'({17'h0, r[14:0]});
		// The sign bit picks between the magnitude and its negation.
		asym_value = r[port_bank_pkg::SIGN_BIT] ? -mag : mag; // R7
	endfunction

	// Merges the two low byte lanes of a write into a sixteen-bit register.
	// Lanes 2 and 3 are ignored, since every sixteen-bit register sits in
	// the low half of its word and the upper half always reads back zero.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Held write address and data; the bus may offer them in either order.
	logic                              aw_held;
	logic [11:0]                       aw_idx;
	logic                              w_held;
	logic [31:0]                       w_data;
	logic [3:0]                        w_strb;
	// Register contents.
	// Each tree instance keeps its own three state bits; the reserved upper
	// bits of the state word are not stored and always read back zero.
	logic [2:0]                        tree_state [port_bank_pkg::INSTANCES];
	logic [port_bank_pkg::POINTER_W-1:0] tree_pointer;
	logic [15:0]                       asymmetry_reg;
	// One captured stamp per class, indexed by the class code.
	logic [31:0]                       stamp [3];
	// Stamp-ready flags, ordered sync, delay request, peer response.
	logic [2:0]                        flags;

	// A write commits once both halves are held.
	wire wr_go = aw_held && w_held;
	// Decoding uses the held index, so a late data beat still hits its address.
	// Lane 0 carries the eight-bit registers, lane 1 the upper half.
	wire lane0 = w_strb[0];
	wire lane1 = w_strb[1];
	// One write strobe per writable register; read-only words decode to none.
	wire wr_pointer = wr_go && aw_idx == port_bank_pkg::IDX_TREE_POINTER;
	wire wr_state   = wr_go && aw_idx == port_bank_pkg::IDX_TREE_STATE;
	wire wr_rx      = wr_go && aw_idx == port_bank_pkg::IDX_RX_LATENCY;
	wire wr_tx      = wr_go && aw_idx == port_bank_pkg::IDX_TX_LATENCY;
	wire wr_asym    = wr_go && aw_idx == port_bank_pkg::IDX_ASYMMETRY;
	wire wr_flags   = wr_go && aw_idx == port_bank_pkg::IDX_STAMP_FLAGS;

	// Read-only stamps accept writes silently so drivers can blank whole ranges.
	function automatic logic mapped(input logic [11:0] i);
		mapped = i == port_bank_pkg::IDX_TREE_POINTER || i == port_bank_pkg::IDX_TREE_STATE
			|| i == port_bank_pkg::IDX_RX_LATENCY || i == port_bank_pkg::IDX_TX_LATENCY
			|| i == port_bank_pkg::IDX_ASYMMETRY || i == port_bank_pkg::IDX_DREQ_HIGH
			|| i == port_bank_pkg::IDX_DREQ_LOW || i == port_bank_pkg::IDX_SYNC_HIGH
			|| i == port_bank_pkg::IDX_SYNC_LOW || i == port_bank_pkg::IDX_PEER_HIGH
			|| i == port_bank_pkg::IDX_PEER_LOW || i == port_bank_pkg::IDX_STAMP_FLAGS;
	endfunction

	// Channels stall while a response is pending, so one write is in flight.
	// Holding off both channels while bvalid stands costs a cycle between
	// writes but keeps the response logic down to a single flag.
	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign arready = !rvalid;

	// Address and data capture, then commit and respond.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Nothing is held and no response is pending after reset.
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_idx  <= 12'h000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= port_bank_pkg::RESP_OKAY;
		end else begin
			// Address taken on its own handshake.
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_idx  <= awaddr[13:2];
			end
			// Data taken on its own handshake.
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			// Commit; an unmapped word answers with a slave error.
			if (wr_go) begin
				// The commit uses the held index and data, never the live bus.
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= mapped(aw_idx) ? port_bank_pkg::RESP_OKAY : port_bank_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				// The master has taken the response; the channels reopen.
				bvalid <= 1'b0;
			end
		end
	end

	// Read selection.
	wire [11:0] rd_idx = araddr[13:2];
	wire [2:0]  rd_state = tree_state[tree_pointer]; // R1
	// A priority chain rather than a case keeps each register on one line; the
	// indices are distinct, so the order of the chain does not matter.
	wire [31:0] rd_word =
		rd_idx == port_bank_pkg::IDX_TREE_POINTER ? {29'h0, tree_pointer} :
		rd_idx == port_bank_pkg::IDX_TREE_STATE   ? {29'h0, rd_state} :
		rd_idx == port_bank_pkg::IDX_RX_LATENCY   ? {16'h0, receive_path_delay_ns} :
		rd_idx == port_bank_pkg::IDX_TX_LATENCY   ? {16'h0, transmit_path_delay_ns} :
		rd_idx == port_bank_pkg::IDX_ASYMMETRY    ? {16'h0, asymmetry_reg} :
		rd_idx == port_bank_pkg::IDX_DREQ_HIGH    ? {16'h0, stamp[0][31:16]} : // R10
		rd_idx == port_bank_pkg::IDX_DREQ_LOW     ? {16'h0, stamp[0][15:0]} : // R10
		rd_idx == port_bank_pkg::IDX_SYNC_HIGH    ? {16'h0, stamp[1][31:16]} : // R11
		rd_idx == port_bank_pkg::IDX_SYNC_LOW     ? {16'h0, stamp[1][15:0]} : // R11
		rd_idx == port_bank_pkg::IDX_PEER_HIGH    ? {16'h0, stamp[2][31:16]} : // R12
		rd_idx == port_bank_pkg::IDX_PEER_LOW     ? {16'h0, stamp[2][15:0]} : // R12
		rd_idx == port_bank_pkg::IDX_STAMP_FLAGS  ? {16'h0, flags, 13'h0} :
		32'h0000_0000;

	// Read answer, one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// No read answer is pending after reset.
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= port_bank_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			// The word is captured here and stands unchanged until rready.
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= mapped(rd_idx) ? port_bank_pkg::RESP_OKAY : port_bank_pkg::RESP_SLVERR;
		end else if (rready) begin
			// Answer taken; arready rises again in the next cycle.
			rvalid <= 1'b0;
		end
	end

	// Pointer that selects which instance the state register reaches.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Instance zero is selected after reset.
			tree_pointer <= port_bank_pkg::POINTER_RESET;
		end else if (wr_pointer && lane0) begin
			// Only lane 0 carries the pointer; bits 7:3 are dropped.
			tree_pointer <= w_data[2:0]; // R1
		end
	end

	// One state per instance; a write lands only on the pointed instance.
	// The gates are plain register bits, so the forwarding logic sees a change
	// from the same edge at which the write response rises.
	genvar gi;
	for (gi = 0; gi < port_bank_pkg::INSTANCES; gi++) begin : g_tree
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				// All instances forward and learn after reset.
				tree_state[gi] <= port_bank_pkg::TREE_STATE_RESET; // R2 R3 R4
			end else if (wr_state && lane0 && tree_pointer == 3'(gi)) begin
				// A write through the pointer reaches exactly one instance.
				tree_state[gi] <= w_data[2:0]; // R1
			end
		end
		// Per-instance gates toward the forwarding logic.
		assign tx_enable[gi]     = tree_state[gi][port_bank_pkg::TX_BIT]; // R2
		assign rx_enable[gi]     = tree_state[gi][port_bank_pkg::RX_BIT]; // R3
		assign learn_disable[gi] = tree_state[gi][port_bank_pkg::LEARN_BIT]; // R4
	end

	// Latency and asymmetry registers with byte-lane writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Latencies return to their defaults and the asymmetry to zero.
			receive_path_delay_ns  <= port_bank_pkg::RX_LATENCY_RESET; // R5
			transmit_path_delay_ns <= port_bank_pkg::TX_LATENCY_RESET; // R6
			asymmetry_reg          <= port_bank_pkg::ASYMMETRY_RESET; // R7 R8
		end else begin
			// Each register merges only the byte lanes that the write enables.
			if (wr_rx) begin
				receive_path_delay_ns <= merge16(receive_path_delay_ns, w_data, w_strb); // R5
			end
			if (wr_tx) begin
				transmit_path_delay_ns <= merge16(transmit_path_delay_ns, w_data, w_strb); // R6
			end
			if (wr_asym) begin
				asymmetry_reg <= merge16(asymmetry_reg, w_data, w_strb); // R7
			end
		end
	end

	// Both words of a class are replaced in one edge, so the pair never tears.
	for (gi = 0; gi < 3; gi++) begin : g_stamp
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				// Stamps read zero until the first frame of their class.
				stamp[gi] <= port_bank_pkg::STAMP_RESET;
			end else if (stamp_in.valid && stamp_in.class_id == port_bank_pkg::stamp_class_e'(gi)) begin
				// A new stamp of this class replaces both words at once.
				stamp[gi] <= stamp_in.value; // R14
			end
		end
	end

	// Flag set sources, ordered as the flag field bits 15..13.
	wire [2:0] flag_set = {3{stamp_in.valid}} & {
		stamp_in.class_id == port_bank_pkg::STAMP_SYNC,
		stamp_in.class_id == port_bank_pkg::STAMP_DELAY_REQ,
		stamp_in.class_id == port_bank_pkg::STAMP_PEER_RESP};
	// Write-one-to-clear through the upper byte lane.
	wire [2:0] flag_clear = (wr_flags && lane1) ? w_data[port_bank_pkg::FLAG_SYNC_BIT:port_bank_pkg::FLAG_PEER_BIT] : 3'h0;
	// A stamp in the clearing cycle still raises its flag.
	// Letting the clear win would lose the notice of that stamp for good,
	// while a spurious extra notice only costs software one more read.
	wire [2:0] next_flags = (flags & ~flag_clear) | flag_set; // R13

	// Sticky stamp-ready flags.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// No stamp is reported as ready after reset.
			flags <= 3'h0;
		end else begin
			// Set and clear are already resolved in next_flags.
			flags <= next_flags; // R13
		end
	end
	// Combined flag level for the port status logic.
	assign stamp_event = |flags; // R13

	// Correction path: ingress Sync and Pdelay_Resp add, egress requests subtract.
	// Only these four message kinds are touched; everything else passes
	// through unchanged with the same one-cycle delay.
	wire add_asym = !correction_in.egress &&
		(correction_in.msg == port_bank_pkg::MSG_SYNC || correction_in.msg == port_bank_pkg::MSG_PEER_RESP);
	wire sub_asym = correction_in.egress &&
		(correction_in.msg == port_bank_pkg::MSG_DELAY_REQ || correction_in.msg == port_bank_pkg::MSG_PEER_REQ);
	wire signed [31:0] asym = asym_value(asymmetry_reg);
	// Wraps modulo 2^32; the field is too wide for this to matter in practice.
	wire [31:0] next_correction = add_asym ? correction_in.value + asym : // R8
		sub_asym ? correction_in.value - asym : correction_in.value; // R9

	// Registered correction output, one cycle behind its input.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Nothing is in flight after reset.
			correction_out <= '0;
		end else begin
			// Every field moves one cycle later; only the value is adjusted.
			correction_out.valid  <= correction_in.valid;
			correction_out.egress <= correction_in.egress;
			correction_out.msg    <= correction_in.msg;
			correction_out.value  <= next_correction; // R8 R9
		end
	end
endmodule // port_ptp_tree_bank
`default_nettype wire

/* File: tb/port_ptp_tree_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the bank's ports; every property runs on aclk and rests while reset is low.
module port_ptp_tree_bank_properties (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       bvalid,
	input wire port_bank_pkg::stamp_s      stamp_in,
	input wire port_bank_pkg::correction_s correction_in,
	input wire port_bank_pkg::correction_s correction_out,
	input wire logic [7:0]                 tx_enable,
	input wire logic [7:0]                 rx_enable,
	input wire logic [7:0]                 learn_disable,
	input wire logic [15:0]                receive_path_delay_ns,
	input wire logic [15:0]                transmit_path_delay_ns,
	input wire logic                       stamp_event
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A captured stamp must show in the summary flag by the next edge.
	sequence s_stamp_seen;
		stamp_in.valid ##1 stamp_event;
	endsequence
	// Levels move only where a write completes; the guard skips the edge that leaves reset.
	sequence s_quiet;
		$past(aresetn) && !$rose(bvalid);
	endsequence
	chk_reset_tree: assert property (
		$rose(aresetn) |-> tx_enable == 8'hFF && rx_enable == 8'hFF && learn_disable == 8'h00)
		else $error("tree levels wrong after reset");
	chk_reset_delay: assert property (
		$rose(aresetn) |-> receive_path_delay_ns == 16'h019F && transmit_path_delay_ns == 16'h002D)
		else $error("path delays wrong after reset");
	chk_tree_quiet: assert property (
		s_quiet |-> $stable(tx_enable) && $stable(rx_enable) && $stable(learn_disable))
		else $error("tree levels moved without a write");
	chk_delay_quiet: assert property (
		s_quiet |-> $stable(receive_path_delay_ns) && $stable(transmit_path_delay_ns))
		else $error("path delays moved without a write");
	chk_stamp_flag: assert property (stamp_in.valid |-> s_stamp_seen)
		else $error("stamp did not raise the event");
	chk_flag_cause: assert property ($rose(stamp_event) |-> $past(stamp_in.valid))
		else $error("event rose without a stamp");
	chk_corr_valid: assert property (
		$past(aresetn) |-> correction_out.valid == $past(correction_in.valid))
		else $error("correction valid not one edge late");
	chk_corr_pass: assert property (
		correction_in.valid && correction_in.msg == port_bank_pkg::MSG_OTHER
		|=> correction_out.value == $past(correction_in.value))
		else $error("other message value altered");
endmodule // port_ptp_tree_bank_properties
bind port_ptp_tree_bank port_ptp_tree_bank_properties u_props (.aclk, .aresetn, .bvalid, .stamp_in,
	.correction_in, .correction_out, .tx_enable, .rx_enable, .learn_disable, .receive_path_delay_ns,
	.transmit_path_delay_ns, .stamp_event);
`default_nettype wire

/* File: tb/port_ptp_tree_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module port_ptp_tree_bank_tb;
	logic                        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready; // Bus strobes.
	logic                        awready, wready, bvalid, arready, rvalid, stamp_event;   // Design answers.
	logic [13:0]                 awaddr, araddr;
	logic [31:0]                 wdata, rdata, rd;
	logic [3:0]                  wstrb;
	logic [1:0]                  bresp, rresp, rs;
	logic [7:0]                  tx_enable, rx_enable, learn_disable;
	logic [15:0]                 receive_path_delay_ns, transmit_path_delay_ns;
	port_bank_pkg::stamp_s       stamp_in;
	port_bank_pkg::correction_s  correction_in, correction_out;
	logic [11:0]                 ridx [11];
	logic [15:0]                 asym [2];
	int                          error_cnt, cmp_count;
	port_ptp_tree_bank uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .stamp_in, .correction_in,
		.correction_out, .tx_enable, .rx_enable, .learn_disable, .receive_path_delay_ns, .transmit_path_delay_ns,
		.stamp_event);
	// Free-running 250 MHz clock.
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// A bus answer that never comes ends the run rather than hanging it.
	task automatic timed_out(input logic miss);
		if (miss) begin
			error_cnt++;
			$display("CHECK FAILED bus answer expected within 50 cycles seen none");
			end_sim();
		end
	endtask
	// Offers address and data together, drops each once taken, holds bready until bvalid.
	task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (bvalid !== 1'h1 && n < 50);
		r = bresp;
		bready <= 1'h0;
		timed_out(bvalid !== 1'h1);
	endtask
	task automatic rd_reg(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			n++;
		end while (rvalid !== 1'h1 && n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		timed_out(rvalid !== 1'h1);
	endtask
	task automatic rchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
		rd_reg(idx, rd, rs);
		chk(what, rd, exp);
		chk("read response", 32'(rs), 32'h0);
	endtask
	// Change the correction field should see: codes 0,1 add on ingress, codes 2,3 subtract on egress.
	function automatic logic [31:0] corr_delta(input logic [15:0] a, input int m, input int e);
		logic [31:0] s;
		s = a[15] ? -{17'h0, a[14:0]} : {17'h0, a[14:0]};
		if (e == 0 && m < 2) return s;
		if (e == 1 && (m == 2 || m == 3)) return -s;
		return 32'h0;
	endfunction
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		stamp_in = '0;
		correction_in = '0;
		error_cnt = 0;
		cmp_count = 0;
		ridx = '{12'hB04, 12'hC00, 12'hC02, 12'hC04, 12'hC08, 12'hC0A, 12'hC0C, 12'hC0E, 12'hC10, 12'hC12, 12'hC14};
		asym = '{16'h0007, 16'h8005};
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (ridx[i]) rchk("reset value", ridx[i], i == 0 ? 32'h6 : i == 1 ? 32'h19F : i == 2 ? 32'h2D : 32'h0);
		$display("Reset values done");
		// Each instance gets its own index as state; the upper bits written are reserved.
		for (int i = 0; i < 8; i++) begin
			wr(12'hB01, 32'(i), 4'h1, rs);
			wr(12'hB04, 32'hF8 | 32'(i), 4'h1, rs);
		end
		for (int i = 0; i < 8; i++) begin
			wr(12'hB01, 32'(i), 4'h1, rs);
			rchk("tree state", 12'hB04, 32'(i));
		end
		chk("transmit enables", 32'(tx_enable), 32'hF0);
		chk("receive enables", 32'(rx_enable), 32'hCC);
		chk("learning stops", 32'(learn_disable), 32'hAA);
		$display("Tree instances done");
		wr(12'hC00, 32'hFFFF_0ACE, 4'hF, rs);
		wr(12'hC02, 32'h0000_B00B, 4'h3, rs);
		rchk("receive delay", 12'hC00, 32'h0ACE);
		rchk("transmit delay", 12'hC02, 32'hB00B);
		chk("receive delay level", 32'(receive_path_delay_ns), 32'h0ACE);
		chk("transmit delay level", 32'(transmit_path_delay_ns), 32'hB00B);
		$display("Path delays done");
		foreach (asym[k]) begin
			wr(12'hC04, 32'(asym[k]), 4'h3, rs);
			rchk("asymmetry", 12'hC04, 32'(asym[k]));
			for (int m = 0; m < 5; m++) begin
				for (int e = 0; e < 2; e++) begin
					@(posedge aclk);
					correction_in <= '{1'h1, e[0], port_bank_pkg::msg_e'(m), 32'h0000_03E8};
					@(posedge aclk);
					correction_in.valid <= 1'h0;
					@(negedge aclk);
					chk("corrected value", correction_out.value, 32'h3E8 + corr_delta(asym[k], m, e));
				end
			end
		end
		$display("Correction done");
		// Each class gets a distinct stamp; the last one overwrites the Sync pair alone.
		for (int c = 0; c < 4; c++) begin
			@(posedge aclk);
			stamp_in <= '{1'h1, port_bank_pkg::stamp_class_e'(c == 3 ? 1 : c), 32'hA5C3_0010 + 32'h0001_0001 * 32'(c)};
			@(posedge aclk);
			stamp_in.valid <= 1'h0;
		end
		wr(12'hC0C, 32'hFFFF_FFFF, 4'hF, rs);
		chk("read-only write response", 32'(rs), 32'h0);
		rchk("delay request high", 12'hC08, 32'hA5C3);
		rchk("delay request low", 12'hC0A, 32'h0010);
		rchk("sync high", 12'hC0C, 32'hA5C6);
		rchk("sync low", 12'hC0E, 32'h0013);
		rchk("peer response high", 12'hC10, 32'hA5C5);
		rchk("peer response low", 12'hC12, 32'h0012);
		rchk("stamp flags", 12'hC14, 32'hE000);
		chk("stamp event", 32'(stamp_event), 32'h1);
		wr(12'hC14, 32'h0000_E000, 4'h2, rs);
		rchk("cleared flags", 12'hC14, 32'h0);
		chk("stamp event cleared", 32'(stamp_event), 32'h0);
		$display("Stamps done");
		rd_reg(12'hFFF, rd, rs);
		chk("unmapped read response", 32'(rs), 32'h2);
		chk("unmapped read data", rd, 32'h0);
		wr(12'hFFF, 32'h1234_5678, 4'hF, rs);
		chk("unmapped write response", 32'(rs), 32'h2);
		$display("Unmapped access done");
		end_sim();
	end
endmodule // port_ptp_tree_bank_tb
`default_nettype wire
